// >>> common/tbtc_pkg.sv
// package: register map, field layout and constants of the timebase timer block
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - timebase is a 10-bit up-counter advanced through a programmable prescaler.
// - software may read the count; writes to the count are ignored.
// - counter halts while the device sleeps.
// - eight prescale ratios 1,2,4,8,16,64,128,256 from a 3-bit select.
// - prescaler divider state clears on every reset.
// - count runs up to the period limit, then restarts at one.
// - period-match flag sets in the same cycle the count restarts.
// - one 8-bit control register at 0x0B: result, route, pwm, run, prescale.
// - comparator result is captured into a readable result bit.
// - upper route bit set drives comparator result onto the port pin.
// - comparator flag sets on every rising and falling output change.
// - comparator interrupt forwarded only when masked in and globally enabled.
// - comparator flag stays set until software clears it.
// - comparator and its flag stay active in sleep; a change wakes the device.
// - flags set regardless of mask; request is the AND of flag, mask and global enable.
package tbtc_pkg;
    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0]  TBTC_REG_IDX_CTRL   = 8'h0B;
    localparam logic [31:0] TBTC_ADDR_CTRL      = 32'h0000_002C;
    localparam logic [31:0] TBTC_ADDR_PERIOD    = 32'h0000_0040;
    localparam logic [31:0] TBTC_ADDR_COUNT     = 32'h0000_0044;
    localparam logic [31:0] TBTC_ADDR_IRQ_MASK  = 32'h0000_0048;
    localparam logic [31:0] TBTC_ADDR_IRQ_STAT  = 32'h0000_004C;
    localparam logic [31:0] TBTC_ADDR_GLOBAL    = 32'h0000_0050;
    localparam int          TBTC_ADDR_LSB       = 2;
    localparam int          TBTC_ADDR_MSB       = 11;
    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int TBTC_CTRL_RESULT     = 7;
    localparam int TBTC_CTRL_ROUTE_HIGH = 6;
    localparam int TBTC_CTRL_ROUTE_LOW  = 5;
    localparam int TBTC_CTRL_PWM_EN     = 4;
    localparam int TBTC_CTRL_RUN        = 3;
    localparam int TBTC_CTRL_PS_MSB     = 2;
    // ****************************************************************
    // interrupt mask and status bits
    // ****************************************************************
    localparam int TBTC_IRQ_CMP_BIT     = 3;
    localparam int TBTC_IRQ_PRD_BIT     = 4;
    // ****************************************************************
    // widths and reset values
    // ****************************************************************
    localparam int          TBTC_CNT_W          = 10;
    localparam int          TBTC_PS_W           = 8;
    localparam logic [6:0]  TBTC_CTRL_RST       = 7'h00;
    localparam logic [9:0]  TBTC_PERIOD_RST     = 10'h3FF;
    localparam logic [9:0]  TBTC_CNT_RESTART    = 10'h001;
    localparam logic [9:0]  TBTC_CNT_ONE        = 10'h001;
    localparam logic [7:0]  TBTC_PS_ONE         = 8'h01;
endpackage

// >>> rtl/tbtc_timer.sv
// timebase timer with comparator event logic, AHB-Lite slave
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module tbtc_timer
    import tbtc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // device state and analogue side
    input  wire logic        sleep_mode,
    input  wire logic        compare_in,
    // pin, wake and interrupt outputs
    output logic             port6_bit0_out,
    output logic             port6_bit0_oe,
    output logic             wake_req,
    output logic             compare_irq,
    output logic             period_irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic        ap_valid;
        logic        ap_write;
        logic [9:0]  ap_index;
        logic [31:0] rdata;
        logic        cmp_sync1;
        logic        cmp_sync2;
        logic        compare_result_bit;
        logic        compare_route_high;
        logic        compare_route_low;
        logic        pwm_output_enable;
        logic        timer_run_enable;
        logic [2:0]  prescale_select;
        logic [9:0]  period_limit;
        logic [9:0]  timebase_count;
        logic [7:0]  prescale_cnt;
        logic        compare_irq_mask;
        logic        period_irq_mask;
        logic        compare_irq_flag;
        logic        period_match_flag;
        logic        global_irq_on_instruction;
        logic        pin_out;
        logic        pin_oe;
        logic        wake;
        logic        cmp_irq;
        logic        prd_irq;
    } tbtc_state_s;

    tbtc_state_s st;
    tbtc_state_s next_st;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // ascending select codes; the 1:32 step is skipped by design
    function automatic logic [7:0] tbtc_ratio_last(input logic [2:0] sel);
        logic [7:0] r;
        r = 8'h00;
        unique case (sel)
            3'h0: r = 8'h00;
            3'h1: r = 8'h01;
            3'h2: r = 8'h03;
            3'h3: r = 8'h07;
            3'h4: r = 8'h0F;
            3'h5: r = 8'h3F;
            3'h6: r = 8'h7F;
            3'h7: r = 8'hFF;
        endcase
        return r;
    endfunction

    function automatic logic [9:0] tbtc_index(input logic [31:0] a);
        return a[TBTC_ADDR_MSB:TBTC_ADDR_LSB];
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    logic        take;
    logic        tick;
    logic        cmp_change;
    logic        prd_match;
    logic [7:0]  ctrl_rd;
    logic [31:0] wd;

    always_comb begin
        next_st    = st;
        take       = hsel && hready && htrans[1];
        wd         = hwdata;
        tick       = 1'b0;
        prd_match  = 1'b0;
        cmp_change = 1'b0;
        ctrl_rd    = {st.compare_result_bit, st.compare_route_high, st.compare_route_low,
                      st.pwm_output_enable, st.timer_run_enable, st.prescale_select};

        // comparator sampling runs also in sleep
        next_st.cmp_sync1 = compare_in;
        next_st.cmp_sync2 = st.cmp_sync1;
        next_st.compare_result_bit = st.cmp_sync2;
        cmp_change = st.cmp_sync2 != st.compare_result_bit;

        // prescaler and counter; sleep or run off freeze both
        if (st.timer_run_enable && !sleep_mode) begin
            if (st.prescale_cnt >= tbtc_ratio_last(st.prescale_select)) begin
                next_st.prescale_cnt = 8'h00;
                tick = 1'b1;
            end else begin
                next_st.prescale_cnt = st.prescale_cnt + TBTC_PS_ONE;
            end
        end
        if (tick) begin
            if (st.timebase_count == st.period_limit) begin
                prd_match                 = 1'b1;
                next_st.timebase_count    = TBTC_CNT_RESTART;
                next_st.period_match_flag = 1'b1;
            end else begin
                next_st.timebase_count = st.timebase_count + TBTC_CNT_ONE;
            end
        end

        // data phase of a write
        if (st.ap_valid && st.ap_write) begin
            unique case (st.ap_index)
                tbtc_index(TBTC_ADDR_CTRL): begin
                    next_st.compare_route_high = wd[TBTC_CTRL_ROUTE_HIGH];
                    next_st.compare_route_low  = wd[TBTC_CTRL_ROUTE_LOW];
                    next_st.pwm_output_enable  = wd[TBTC_CTRL_PWM_EN];
                    next_st.timer_run_enable   = wd[TBTC_CTRL_RUN];
                    next_st.prescale_select    = wd[TBTC_CTRL_PS_MSB:0];
                end
                tbtc_index(TBTC_ADDR_PERIOD): next_st.period_limit = wd[TBTC_CNT_W-1:0];
                tbtc_index(TBTC_ADDR_COUNT):  ;
                tbtc_index(TBTC_ADDR_IRQ_MASK): begin
                    next_st.compare_irq_mask = wd[TBTC_IRQ_CMP_BIT];
                    next_st.period_irq_mask  = wd[TBTC_IRQ_PRD_BIT];
                end
                tbtc_index(TBTC_ADDR_IRQ_STAT): begin
                    // write zero clears; a same-cycle event wins
                    if (!wd[TBTC_IRQ_CMP_BIT] && !cmp_change)
                        next_st.compare_irq_flag = 1'b0;
                    // only a real match beats the clear, not every tick
                    if (!wd[TBTC_IRQ_PRD_BIT] && !prd_match)
                        next_st.period_match_flag = 1'b0;
                end
                tbtc_index(TBTC_ADDR_GLOBAL): next_st.global_irq_on_instruction = wd[0];
                default: ;
            endcase
        end
        if (cmp_change)
            next_st.compare_irq_flag = 1'b1;

        // address phase; zero-wait answer
        next_st.ap_valid = take;
        next_st.ap_write = hwrite;
        next_st.ap_index = tbtc_index(haddr);
        next_st.rdata    = 32'h0000_0000;
        if (take && !hwrite) begin
            unique case (tbtc_index(haddr))
                tbtc_index(TBTC_ADDR_CTRL):     next_st.rdata = {24'h00_0000, ctrl_rd};
                tbtc_index(TBTC_ADDR_PERIOD):   next_st.rdata = {22'h00_0000, st.period_limit};
                tbtc_index(TBTC_ADDR_COUNT):    next_st.rdata = {22'h00_0000, st.timebase_count};
                tbtc_index(TBTC_ADDR_IRQ_MASK): begin
                    next_st.rdata[TBTC_IRQ_CMP_BIT] = st.compare_irq_mask;
                    next_st.rdata[TBTC_IRQ_PRD_BIT] = st.period_irq_mask;
                end
                tbtc_index(TBTC_ADDR_IRQ_STAT): begin
                    next_st.rdata[TBTC_IRQ_CMP_BIT] = st.compare_irq_flag;
                    next_st.rdata[TBTC_IRQ_PRD_BIT] = st.period_match_flag;
                end
                tbtc_index(TBTC_ADDR_GLOBAL):   next_st.rdata[0] = st.global_irq_on_instruction;
                default:                        next_st.rdata = 32'h0000_0000;
            endcase
        end

        // pin routing, wake and requests
        next_st.pin_oe  = next_st.compare_route_high;
        next_st.pin_out = next_st.compare_route_high & next_st.compare_result_bit;
        next_st.wake    = sleep_mode && cmp_change;
        next_st.cmp_irq = next_st.compare_irq_flag && next_st.compare_irq_mask
                          && next_st.global_irq_on_instruction;
        next_st.prd_irq = next_st.period_match_flag && next_st.period_irq_mask
                          && next_st.global_irq_on_instruction;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // one reset clears all but period limit (0x3FF) and count (one), prescaler included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st                  <= '0;
            st.period_limit     <= TBTC_PERIOD_RST;
            st.timebase_count   <= TBTC_CNT_RESTART;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign hrdata         = st.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign port6_bit0_out = st.pin_out;
    assign port6_bit0_oe  = st.pin_oe;
    assign wake_req       = st.wake;
    assign compare_irq    = st.cmp_irq;
    assign period_irq     = st.prd_irq;
endmodule

// >>> testbench/tbtc_timer_checker.sv
// checker: bus, pin, interrupt and wake relations at the timer ports
`timescale 1ns/1ps
module tbtc_timer_checker (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       clk_en,
    // bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // device side
    input wire logic       sleep_mode,
    input wire logic       compare_in,
    input wire logic       port6_bit0_out,
    input wire logic       port6_bit0_oe,
    input wire logic       wake_req,
    input wire logic       compare_irq,
    input wire logic       period_irq
);
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr;
    // only a taken write may move software-owned state
    assign wr = hsel && htrans[1] && hwrite && clk_en;
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_pin_gated: assert property (port6_bit0_out |-> port6_bit0_oe) else $error("pin driven unrouted");
    a_route_write: assert property ($changed(port6_bit0_oe) |-> $past(wr, 2) || $past(wr, 3))
        else $error("route moved without write");
    a_cmp_irq_hold: assert property ($fell(compare_irq) |-> $past(wr, 2) || $past(wr, 3))
        else $error("compare irq dropped alone");
    a_prd_irq_hold: assert property ($fell(period_irq) |-> $past(wr, 2) || $past(wr, 3))
        else $error("period irq dropped alone");
    a_wake_asleep: assert property (wake_req |-> $past(sleep_mode)) else $error("wake while awake");
    a_wake_change: assert property (sleep_mode && clk_en && $changed(compare_in) |-> ##[1:5] wake_req)
        else $error("no wake on change");
endmodule
bind tbtc_timer tbtc_timer_checker tbtc_timer_checker_i (.hclk, .hresetn, .clk_en, .hsel, .htrans, .hwrite,
    .hreadyout, .hresp, .sleep_mode, .compare_in, .port6_bit0_out, .port6_bit0_oe, .wake_req, .compare_irq,
    .period_irq);

// >>> testbench/tbtc_timer_tb_top.sv
// testbench: register, timer and comparator scenarios for the timer block
`timescale 1ns/1ps
module tbtc_timer_tb_top;
    import tbtc_pkg::*;
    // ****************************************************************
    // stimulus and checking
    // ****************************************************************
    logic        hclk = 0, hresetn = 0, clk_en = 1, hsel = 1, hwrite = 0;
    logic        sleep_mode = 0, compare_in = 0, b, chg;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, c1;
    logic        hreadyout, hresp, p_out, p_oe, wake_req, compare_irq, period_irq;
    int          err_total = 0, n_compared = 0, seed = 44, p;
    tbtc_timer tbtc_timer_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .compare_in(compare_in),
        .port6_bit0_out(p_out), .port6_bit0_oe(p_oe), .wake_req(wake_req), .compare_irq(compare_irq),
        .period_irq(period_irq));
    initial begin
        forever #5 hclk = ~hclk;
    end
    function automatic int ratio(input int c);
        int r [8] = '{1, 2, 4, 8, 16, 64, 128, 256};
        return r[c];
    endfunction
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task cy(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // bounded wait: a stuck slave ends the run
    task hwait;
        int   k;
        logic rdy;
        k = 0;
        do begin
            // sample mid-cycle: values stand unchanged up to the next rising edge
            @(negedge hclk);
            rdy = hreadyout;
            rd  = hrdata;
            @(posedge hclk);
            k++;
            if (k > 16) begin
                err_total++;
                end_of_test;
            end
        end while (rdy !== 1'b1);
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        hwait;
        htrans <= 2'b00;
        hwdata <= d;
        hwait;
    endtask
    // count drift over a 40-cycle gap, optionally with the clock enable low
    task hold(input logic g, input int dmax);
        xfer(0, TBTC_ADDR_COUNT, 0);
        c1 = rd;
        clk_en <= !g;
        cy(40);
        clk_en <= 1;
        xfer(0, TBTC_ADDR_COUNT, 0);
        chk("count drift", 32'(rd - c1 <= dmax), 1);
    endtask
    initial begin
        cy(8);
        hresetn <= 1;
        cy(1);
        xfer(0, TBTC_ADDR_CTRL, 0);
        chk("ctrl reset", rd, 0);
        xfer(1, TBTC_ADDR_COUNT, 32'h0000_0200);
        xfer(0, TBTC_ADDR_COUNT, 0);
        chk("count reset", rd, 1);
        p = 2 + {$random(seed)} % 4;
        xfer(1, TBTC_ADDR_PERIOD, 32'(p));
        xfer(1, TBTC_ADDR_GLOBAL, 32'h0000_0001);
        xfer(1, TBTC_ADDR_CTRL, 32'h0000_0008);
        repeat (12) begin
            xfer(0, TBTC_ADDR_COUNT, 0);
            chk("count range", 32'(rd >= 1 && rd <= p), 1);
        end
        xfer(0, TBTC_ADDR_IRQ_STAT, 0);
        chk("period flag", 32'(rd[4] && !period_irq), 1);
        xfer(1, TBTC_ADDR_IRQ_MASK, 32'h0000_0010);
        cy(3);
        chk("period irq", 32'(period_irq), 1);
        xfer(1, TBTC_ADDR_CTRL, 0);
        xfer(1, TBTC_ADDR_IRQ_STAT, 0);
        cy(p + 3);
        chk("period cleared", 32'(period_irq), 0);
        xfer(1, TBTC_ADDR_PERIOD, 32'h0000_03FF);
        for (int c = 0; c < 8; c++) begin
            xfer(1, TBTC_ADDR_CTRL, 32'(8 + c));
            xfer(0, TBTC_ADDR_COUNT, 0);
            c1 = rd;
            cy(8 * ratio(c));
            xfer(0, TBTC_ADDR_COUNT, 0);
            chk("ticks", 32'(rd - c1 >= 8 && rd - c1 <= 9 + 4 / ratio(c)), 1);
        end
        xfer(1, TBTC_ADDR_CTRL, 32'h0000_0008);
        hold(1, 5);
        sleep_mode <= 1;
        hold(0, 0);
        compare_in <= ~compare_in;
        cy(8);
        xfer(0, TBTC_ADDR_IRQ_STAT, 0);
        chk("sleep flag", 32'(rd[3]), 1);
        sleep_mode <= 0;
        xfer(1, TBTC_ADDR_CTRL, 0);
        hold(0, 0);
        xfer(1, TBTC_ADDR_IRQ_STAT, 0);
        for (int i = 0; i < 6; i++) begin
            xfer(1, TBTC_ADDR_IRQ_MASK, i[0] ? 32'h0000_0000 : 32'h0000_0008);
            xfer(1, TBTC_ADDR_GLOBAL, 32'(i != 4));
            xfer(1, TBTC_ADDR_CTRL, 32'(i[1]) << 6);
            b = (i < 3) ? ~compare_in : 1'($random(seed));
            chg = b ^ compare_in;
            compare_in <= b;
            cy(6);
            xfer(0, TBTC_ADDR_CTRL, 0);
            chk("result", 32'(rd[7]), 32'(b));
            chk("pin", 32'({p_oe, p_out}), 32'({i[1], i[1] & b}));
            xfer(0, TBTC_ADDR_IRQ_STAT, 0);
            chk("cmp flag", 32'(rd[3]), 32'(chg));
            chk("cmp irq", 32'(compare_irq), 32'(chg & ~i[0] & (i != 4)));
            xfer(1, TBTC_ADDR_IRQ_STAT, 0);
            xfer(0, TBTC_ADDR_IRQ_STAT, 0);
            chk("cmp clear", 32'(rd[3]), 0);
        end
        xfer(0, 32'h0000_03FC, 0);
        chk("unmapped", rd, 0);
        end_of_test;
    end
endmodule
